// ===== src/ssi_consts.svh
/*
 * Shared constants of the serial position readout link: word size, timing figures and buffer depth.
 * Assumes a 100 MHz system clock on both ends; all counts derive from the figures here.
 */
`ifndef SSI_CONSTS_SVH
`define SSI_CONSTS_SVH

// system clock rate in MHz
`define SSI_CLK_MHZ 100
// position resolution in bits
`define SSI_RES_BITS 13
// monoflop timeout, longest time, ns
`define SSI_MONO_NS 40000
// monoflop timeout in cycles, rounded down
`define SSI_MONO_CYC ((`SSI_MONO_NS * `SSI_CLK_MHZ) / 1000)
// half clock period made by the controller, ns
`define SSI_HALF_NS 1000
`define SSI_HALF_CYC ((`SSI_HALF_NS * `SSI_CLK_MHZ + 999) / 1000)
// idle gap between bursts, longer than the monoflop timeout, ns
`define SSI_GAP_NS 50000
`define SSI_GAP_CYC ((`SSI_GAP_NS * `SSI_CLK_MHZ + 999) / 1000)
// idle gap for a repeat read, well inside the monoflop timeout, ns
`define SSI_REPEAT_NS 10000
`define SSI_REPEAT_CYC ((`SSI_REPEAT_NS * `SSI_CLK_MHZ + 999) / 1000)
// receive buffer depth in words
`define SSI_FIFO_DEPTH 32

`endif

// ===== src/ssi_pkg.sv
/*
 * Types shared by both ends of the serial position readout link.
 * Assumes ssi_consts.svh supplies all numeric constants.
 */
package ssi_pkg;

    typedef enum logic [1:0] {
        ENC_IDLE = 2'b00,
        ENC_SHIFT = 2'b01,
        ENC_HOLD = 2'b10
    } ssi_enc_state_t;

    typedef enum logic [1:0] {
        CTL_IDLE = 2'b00,
        CTL_LOW = 2'b01,
        CTL_HIGH = 2'b10,
        CTL_GAP = 2'b11
    } ssi_ctl_state_t;

endpackage

// ===== src/ssi_if.sv
/*
 * Two-wire serial readout link: clock from the controller, data from the encoder.
 * Assumes both ends run on their own system clocks; both wires are one-way, push-pull.
 */
`timescale 1ns/100ps
`default_nettype none

interface ssi_if;
    logic sclk;
    logic sdata;

    modport enc (input sclk, output sdata);
    modport ctl (output sclk, input sdata);
endinterface

`default_nettype wire

// ===== src/ssi_enc.sv
/*
 * Encoder end of the serial position readout: with UPDATE_IMMEDIATE set, captures the position on the first falling clock edge,
 * shifts it out MSB first on rising edges, then holds data low for the monoflop timeout.
 * Assumes the link clock comes from the controller and is asynchronous to SYS_CLK; POSITION and the
 * configuration inputs come from logic on SYS_CLK.
 */
`timescale 1ns/100ps
`default_nettype none
`include "ssi_consts.svh"

module ssi_enc #(
    parameter int RES_BITS = `SSI_RES_BITS,
    parameter int MONO_CYC = `SSI_MONO_CYC
) (
    // system
    input wire logic SYS_CLK,
    input wire logic NRST,
    // position source and configuration
    input wire logic [RES_BITS-1:0] POSITION,
    input wire logic CODE_GRAY,
    input wire logic CODE_REVERSE,
    input wire logic UPDATE_IMMEDIATE,
    // status
    output logic BUSY,
    output logic WORD_DONE,
    output logic WORD_ABORT,
    // link
    ssi_if.enc LINK
);
    import ssi_pkg::*;

    localparam int MW = $clog2(MONO_CYC + 1);
    localparam int BW = $clog2(RES_BITS + 1);

    ssi_enc_state_t state;
    logic sclk_meta;
    logic sclk_sync;
    logic sclk_prev;
    logic clk_fall;
    logic clk_rise;
    logic [MW-1:0] mono_cnt;
    logic mono_expired;
    logic [RES_BITS-1:0] coded;
    logic [RES_BITS-1:0] gray;
    logic [RES_BITS-1:0] ready_word;
    logic [RES_BITS-1:0] sent_word;
    logic [RES_BITS-1:0] shreg;
    logic [BW-1:0] bit_cnt;
    logic word_stale;
    logic sdata;

    // sync flops reset to the idle level so release from reset never looks like an edge
    always_ff @(posedge SYS_CLK)
    begin
        if (!NRST)
        begin
            sclk_meta <= 1'b1;
            sclk_sync <= 1'b1;
            sclk_prev <= 1'b1;
        end
        else
        begin
            sclk_meta <= LINK.sclk;
            sclk_sync <= sclk_meta;
            sclk_prev <= sclk_sync;
        end
    end

    assign clk_fall = sclk_prev & ~sclk_sync;
    assign clk_rise = ~sclk_prev & sclk_sync;

    // position coding: plain binary or single-step code, the single-step code with optional direction reversal
    assign gray = POSITION ^ (POSITION >> 1);
    always_comb
    begin
        coded = CODE_GRAY ? gray : POSITION;
        if (CODE_GRAY && CODE_REVERSE)
        begin
            coded[RES_BITS-1] = ~gray[RES_BITS-1];
        end
    end

    // monoflop: reloads on every clock edge, runs down while a readout is in progress
    always_ff @(posedge SYS_CLK)
    begin
        if (!NRST)
        begin
            mono_cnt <= '0;
        end
        else if (clk_fall || clk_rise)
        begin
            mono_cnt <= MW'(MONO_CYC);
        end
        else if (state != ENC_IDLE && mono_cnt != '0)
        begin
            mono_cnt <= mono_cnt - MW'(1);
        end
    end

    assign mono_expired = (mono_cnt == '0) && !clk_fall && !clk_rise;

    // sequential variant: a fresh word is fetched only once the previous one was fully delivered
    always_ff @(posedge SYS_CLK)
    begin
        if (!NRST)
        begin
            ready_word <= '0;
            word_stale <= 1'b1;
        end
        else if (state == ENC_HOLD && mono_expired)
        begin
            word_stale <= 1'b1;
        end
        else if (state == ENC_IDLE && word_stale && !clk_fall)
        begin
            ready_word <= coded;
            word_stale <= 1'b0;
        end
    end

    // readout sequencer
    always_ff @(posedge SYS_CLK)
    begin
        if (!NRST)
        begin
            state <= ENC_IDLE;
            shreg <= '0;
            sent_word <= '0;
            bit_cnt <= '0;
            sdata <= 1'b1;
        end
        else
        begin
            case (state)
                ENC_IDLE:
                begin
                    sdata <= 1'b1;
                    if (clk_fall)
                    begin
                        // sequential variant hands out the word refreshed after the last readout;
                        // a fetch racing this fall would be one cycle late, so take coded directly then
                        if (UPDATE_IMMEDIATE || word_stale)
                        begin
                            shreg <= coded;
                            sent_word <= coded;
                        end
                        else
                        begin
                            shreg <= ready_word;
                            sent_word <= ready_word;
                        end
                        bit_cnt <= '0;
                        state <= ENC_SHIFT;
                    end
                end
                ENC_SHIFT:
                begin
                    if (clk_rise)
                    begin
                        if (bit_cnt == BW'(RES_BITS))
                        begin
                            sdata <= 1'b0;
                            state <= ENC_HOLD;
                        end
                        else
                        begin
                            sdata <= shreg[RES_BITS-1];
                            shreg <= shreg << 1;
                            bit_cnt <= bit_cnt + BW'(1);
                        end
                    end
                    else if (mono_expired)
                    begin
                        sdata <= 1'b1;
                        state <= ENC_IDLE;
                    end
                end
                ENC_HOLD:
                begin
                    if (clk_fall && UPDATE_IMMEDIATE)
                    begin
                        shreg <= sent_word;
                        bit_cnt <= '0;
                        state <= ENC_SHIFT;
                    end
                    else if (mono_expired)
                    begin
                        sdata <= 1'b1;
                        state <= ENC_IDLE;
                    end
                end
                default:
                begin
                    sdata <= 1'b1;
                    state <= ENC_IDLE;
                end
            endcase
        end
    end

    assign LINK.sdata = sdata;

    // status: BUSY level plus one-cycle WORD_DONE and WORD_ABORT pulses, all registered
    always_ff @(posedge SYS_CLK)
    begin
        if (!NRST)
        begin
            BUSY <= 1'b0;
            WORD_DONE <= 1'b0;
            WORD_ABORT <= 1'b0;
        end
        else
        begin
            BUSY <= (state != ENC_IDLE);
            WORD_DONE <= (state == ENC_SHIFT) && clk_rise && (bit_cnt == BW'(RES_BITS));
            WORD_ABORT <= (state == ENC_SHIFT) && !clk_rise && mono_expired;
        end
    end

endmodule // ssi_enc

`default_nettype wire

// ===== src/ssi_ctl.sv
/*
 * Controller end of the serial position readout: makes the clock burst, samples the data bits
 * and queues each complete word in a receive buffer.
 * Assumes the encoder data arrives asynchronously; the user side drains the buffer on SYS_CLK.
 */
`timescale 1ns/100ps
`default_nettype none
`include "ssi_consts.svh"

module ssi_fifo #(
    parameter int WIDTH = `SSI_RES_BITS,
    parameter int DEPTH = `SSI_FIFO_DEPTH
) (
    // system
    input wire logic SYS_CLK,
    input wire logic NRST,
    // fill side
    input wire logic IN_VALID,
    output logic IN_READY,
    input wire logic [WIDTH-1:0] IN_DATA,
    // drain side
    output logic OUT_VALID,
    input wire logic OUT_READY,
    output logic [WIDTH-1:0] OUT_DATA
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
    logic do_wr;
    logic do_rd;

    assign IN_READY = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
    assign OUT_VALID = wr_ptr != rd_ptr;
    assign OUT_DATA = mem[rd_ptr[AW-1:0]];
    assign do_wr = IN_VALID && IN_READY;
    assign do_rd = OUT_VALID && OUT_READY;

    always_ff @(posedge SYS_CLK)
    begin
        if (do_wr)
        begin
            mem[wr_ptr[AW-1:0]] <= IN_DATA;
        end
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (!NRST)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end
        else
        begin
            if (do_wr)
            begin
                wr_ptr <= wr_ptr + (AW+1)'(1);
            end
            if (do_rd)
            begin
                rd_ptr <= rd_ptr + (AW+1)'(1);
            end
        end
    end

endmodule // ssi_fifo

module ssi_ctl #(
    parameter int RES_BITS = `SSI_RES_BITS,
    parameter int HALF_CYC = `SSI_HALF_CYC,
    parameter int GAP_CYC = `SSI_GAP_CYC,
    parameter int REPEAT_CYC = `SSI_REPEAT_CYC,
    parameter int FIFO_DEPTH = `SSI_FIFO_DEPTH
) (
    // system
    input wire logic SYS_CLK,
    input wire logic NRST,
    // request
    input wire logic START,
    input wire logic REPEAT,
    input wire logic ABORT,
    output logic BUSY,
    // received words
    output logic OUT_VALID,
    input wire logic OUT_READY,
    output logic [RES_BITS-1:0] OUT_DATA,
    // link
    ssi_if.ctl LINK
);
    import ssi_pkg::*;

    localparam int TW = $clog2(GAP_CYC + HALF_CYC + REPEAT_CYC + 1);
    localparam int BW = $clog2(RES_BITS + 2);

    ssi_ctl_state_t state;
    logic [TW-1:0] timer;
    logic [BW-1:0] edge_cnt;
    logic [RES_BITS-1:0] rx_word;
    logic sdata_meta;
    logic sdata_sync;
    logic sclk;
    logic push;
    logic fifo_ready;

    always_ff @(posedge SYS_CLK)
    begin
        if (!NRST)
        begin
            sdata_meta <= 1'b1;
            sdata_sync <= 1'b1;
        end
        else
        begin
            sdata_meta <= LINK.sdata;
            sdata_sync <= sdata_meta;
        end
    end

    // burst generator: half periods of HALF_CYC cycles, n+1 falling and n+1 rising edges
    always_ff @(posedge SYS_CLK)
    begin
        if (!NRST)
        begin
            state <= CTL_IDLE;
            timer <= '0;
            edge_cnt <= '0;
            rx_word <= '0;
            sclk <= 1'b1;
            push <= 1'b0;
        end
        else
        begin
            push <= 1'b0;
            case (state)
                CTL_IDLE:
                begin
                    sclk <= 1'b1;
                    // no burst without room: a full buffer stalls the readout
                    if (START && fifo_ready)
                    begin
                        sclk <= 1'b0;
                        edge_cnt <= '0;
                        timer <= TW'(HALF_CYC - 1);
                        state <= CTL_LOW;
                    end
                end
                CTL_LOW:
                begin
                    if (timer != '0)
                    begin
                        timer <= timer - TW'(1);
                    end
                    else
                    begin
                        sclk <= 1'b1;
                        edge_cnt <= edge_cnt + BW'(1);
                        timer <= TW'(HALF_CYC - 1);
                        if (edge_cnt == BW'(RES_BITS))
                        begin
                            push <= 1'b1;
                            timer <= REPEAT ? TW'(REPEAT_CYC - 1) : TW'(GAP_CYC - 1);
                            state <= CTL_GAP;
                        end
                        else
                        begin
                            state <= CTL_HIGH;
                        end
                    end
                end
                CTL_HIGH:
                begin
                    if (ABORT)
                    begin
                        timer <= TW'(GAP_CYC - 1);
                        state <= CTL_GAP;
                    end
                    else if (timer != '0)
                    begin
                        timer <= timer - TW'(1);
                    end
                    else
                    begin
                        // sample late in the high half, after the encoder's sync delay
                        rx_word <= {rx_word[RES_BITS-2:0], sdata_sync};
                        sclk <= 1'b0;
                        timer <= TW'(HALF_CYC - 1);
                        state <= CTL_LOW;
                    end
                end
                CTL_GAP:
                begin
                    sclk <= 1'b1;
                    if (timer != '0)
                    begin
                        timer <= timer - TW'(1);
                    end
                    else
                    begin
                        state <= CTL_IDLE;
                    end
                end
                default:
                begin
                    sclk <= 1'b1;
                    state <= CTL_IDLE;
                end
            endcase
        end
    end

    assign LINK.sclk = sclk;
    assign BUSY = (state != CTL_IDLE);

    ssi_fifo #(
        .WIDTH(RES_BITS),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .SYS_CLK(SYS_CLK),
        .NRST(NRST),
        .IN_VALID(push),
        .IN_READY(fifo_ready),
        .IN_DATA(rx_word),
        .OUT_VALID(OUT_VALID),
        .OUT_READY(OUT_READY),
        .OUT_DATA(OUT_DATA)
    );

endmodule // ssi_ctl

`default_nettype wire

// ===== bench/ssi_link_props.sv
/*
 * Checker for the readout link wires and the encoder status pulses.
 * Assumes one instance beside the link interface, on the encoder's system clock.
 */
`timescale 1ns/100ps
`default_nettype none

module ssi_link_props #(
    parameter int RES_BITS = 13,
    parameter int MONO_CYC = 200,
    parameter int HALF_CYC = 8
) (
    // system
    input wire logic SYS_CLK,
    input wire logic NRST,
    // link
    input wire logic sclk,
    input wire logic sdata,
    // encoder status
    input wire logic BUSY,
    input wire logic WORD_DONE,
    input wire logic WORD_ABORT
);
    logic sclk_q;
    int quiet;
    int rises;

    // cycles since the last clock edge, saturating far above the timeout
    always_ff @(posedge SYS_CLK)
    begin
        // reset counts as a long idle, so the first burst is not taken for a short high half
        if (!NRST)
            quiet <= 100000;
        else if (sclk != sclk_q)
            quiet <= 0;
        else if (quiet < 100000)
            quiet <= quiet + 1;
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (!NRST)
            sclk_q <= 1'b1;
        else
            sclk_q <= sclk;
    end

    // a fall after a long high starts a new burst count
    always_ff @(posedge SYS_CLK)
    begin
        if (!NRST)
            rises <= 0;
        else if (!sclk && sclk_q && quiet > 2 * HALF_CYC + 4)
            rises <= 0;
        else if (sclk && !sclk_q)
            rises <= rises + 1;
    end

    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (!NRST);

    idle_high_a: assert property ($rose(NRST) |-> sclk && sdata)
        else $error("link not idle high");
    edge_timing_a: assert property ($changed(sdata) |-> quiet <= 8 || (quiet >= MONO_CYC - 4 && quiet <= MONO_CYC + 8))
        else $error("data moved away from a clock edge or timeout");
    timeout_max_a: assert property (sclk && !sdata |-> quiet <= MONO_CYC + 8)
        else $error("data held low beyond timeout");
    low_half_a: assert property (!sclk && !sclk_q |-> quiet <= HALF_CYC + 2)
        else $error("clock low half too long");
    high_half_a: assert property ($fell(sclk) |-> quiet >= HALF_CYC - 2)
        else $error("clock high half too short");
    burst_gap_a: assert property ($fell(sclk) && quiet > 2 * HALF_CYC + 4 |-> quiet > MONO_CYC + 4 || quiet < MONO_CYC - 20)
        else $error("burst started near the timeout");
    done_count_a: assert property (WORD_DONE |-> rises == RES_BITS + 1)
        else $error("word done after wrong rise count");
    done_low_a: assert property (WORD_DONE |-> ##[0:4] (!sdata [*8]))
        else $error("data not low after last bit");
    abort_high_a: assert property (WORD_ABORT |-> ##[0:4] (sdata && sclk))
        else $error("data not high after abort");
    start_busy_a: assert property ($fell(sclk) && quiet > MONO_CYC + 4 |-> ##[1:6] BUSY)
        else $error("encoder missed burst start");

    cover property (WORD_DONE);
    cover property (WORD_ABORT);
    cover property ($fell(sclk) && quiet > 30 && quiet < MONO_CYC - 20);
endmodule // ssi_link_props

`default_nettype wire

// ===== bench/ssi_position_encoder_readout_tb.sv
/*
 * Bench joining encoder and controller ends over the link; reads words in every mode.
 * Assumes shortened timeout and gaps so a full buffer fill stays short.
 */
`timescale 1ns/100ps
`default_nettype none

module ssi_position_encoder_readout_tb;
    localparam int RES = 13;
    localparam int MONO = 200;
    localparam int HALF = 8;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic [RES-1:0] position = 13'h0000;
    logic code_gray = 1'b0;
    logic code_reverse = 1'b0;
    logic update_immediate = 1'b1;
    logic start = 1'b0;
    logic repeat_rd = 1'b0;
    logic abort = 1'b0;
    logic out_ready = 1'b0;
    logic enc_busy, word_done, word_abort, ctl_busy, out_valid;
    logic [RES-1:0] out_data;
    logic [RES:0] wire_sr = '0;
    logic sclk_q = 1'b1;
    int mismatches = 0;
    int total_checks = 0;
    int done_cnt = 0;
    int rise_cnt = 0;
    logic [RES-1:0] tbl [3] = '{13'h0000, 13'h1FFF, 13'h1A5B};

    ssi_if link();
    always #5 sys_clk = ~sys_clk;

    ssi_enc #(.RES_BITS(RES), .MONO_CYC(MONO)) u_ssi_enc (.SYS_CLK(sys_clk), .NRST(nrst), .POSITION(position),
        .CODE_GRAY(code_gray), .CODE_REVERSE(code_reverse), .UPDATE_IMMEDIATE(update_immediate),
        .BUSY(enc_busy), .WORD_DONE(word_done), .WORD_ABORT(word_abort), .LINK(link));
    ssi_ctl #(.RES_BITS(RES), .HALF_CYC(HALF), .GAP_CYC(300), .REPEAT_CYC(50), .FIFO_DEPTH(32)) u_ssi_ctl (
        .SYS_CLK(sys_clk), .NRST(nrst), .START(start), .REPEAT(repeat_rd), .ABORT(abort), .BUSY(ctl_busy),
        .OUT_VALID(out_valid), .OUT_READY(out_ready), .OUT_DATA(out_data), .LINK(link));
    ssi_link_props #(.RES_BITS(RES), .MONO_CYC(MONO), .HALF_CYC(HALF)) u_ssi_link_props (.SYS_CLK(sys_clk),
        .NRST(nrst), .sclk(link.sclk), .sdata(link.sdata), .BUSY(enc_busy), .WORD_DONE(word_done),
        .WORD_ABORT(word_abort));

    // wire monitor: the controller samples data just before each fall after the first, we take it in the cycle after every fall
    always @(posedge sys_clk)
    begin
        sclk_q <= link.sclk;
        if (word_done === 1'b1)
            done_cnt <= done_cnt + 1;
        if (sclk_q && !link.sclk)
            wire_sr <= {wire_sr[RES-1:0], link.sdata};
        if (!sclk_q && link.sclk)
            rise_cnt <= rise_cnt + 1;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic hang(input int n);
        if (n >= 40000)
        begin
            mismatches++;
            $display("Error at %0t: wait ran out", $time);
            tally_and_finish();
        end
    endtask

    function automatic logic [RES-1:0] coded(input logic [RES-1:0] p, input logic g, input logic r);
        return g ? ((p ^ (p >> 1)) ^ {r, {(RES-1){1'b0}}}) : p;
    endfunction

    // which: 0 valid word, 1 abort pulse, 2 controller idle
    task automatic wait_for(input int which);
        int i;
        i = 0;
        do
        begin
            @(negedge sys_clk);
            i++;
        end
        while (i < 40000 && (which == 0 ? out_valid !== 1'b1 : which == 1 ? word_abort !== 1'b1 : ctl_busy !== 1'b0));
        hang(i);
    endtask

    task automatic get_word(input logic [RES-1:0] exp);
        wait_for(0);
        check(out_data, exp);
        @(posedge sys_clk);
        out_ready <= 1'b1;
        @(posedge sys_clk);
        out_ready <= 1'b0;
    endtask

    task automatic read_word(input logic [RES-1:0] exp, input logic rpt);
        wait_for(2);
        @(posedge sys_clk);
        rise_cnt <= 0;
        repeat_rd <= rpt;
        start <= 1'b1;
        @(posedge sys_clk);
        start <= 1'b0;
        get_word(exp);
        check(wire_sr[RES-1:0], exp);
        check(rise_cnt, RES + 1);
        // the encoder needs a few cycles to see the last rise through its synchroniser
        repeat (4) @(posedge sys_clk);
        check(link.sdata, 1'b0);
    endtask

    task automatic t_codes();
        for (int m = 0; m < 3; m++)
        begin
            @(posedge sys_clk);
            code_gray <= (m > 0);
            code_reverse <= (m == 2);
            position <= tbl[m];
            read_word(coded(tbl[m], m > 0, m == 2), 1'b0);
        end
        code_gray <= 1'b0;
        $display("codes test done");
    endtask

    // sequential variant: the word changed between reads must be the fresh one
    task automatic t_seq();
        update_immediate <= 1'b0;
        position <= 13'h0A5A;
        read_word(13'h0A5A, 1'b0);
        position <= 13'h15A5;
        read_word(13'h15A5, 1'b0);
        update_immediate <= 1'b1;
        $display("sequential test done");
    endtask

    task automatic t_repeat();
        position <= 13'h0123;
        read_word(13'h0123, 1'b1);
        position <= 13'h1ED0;
        read_word(13'h0123, 1'b0);
        read_word(13'h1ED0, 1'b0);
        $display("repeat test done");
    endtask

    task automatic t_abort();
        wait_for(2);
        @(posedge sys_clk);
        start <= 1'b1;
        @(posedge sys_clk);
        start <= 1'b0;
        repeat (5 * 2 * HALF) @(posedge sys_clk);
        abort <= 1'b1;
        wait_for(1);
        repeat (6) @(negedge sys_clk);
        check(link.sdata, 1'b1);
        check(out_valid, 1'b0);
        @(posedge sys_clk);
        abort <= 1'b0;
        read_word(13'h1ED0, 1'b0);
        $display("abort test done");
    endtask

    // fill until the buffer refuses further bursts, then drain it empty
    task automatic t_fifo();
        int base;
        int i;
        base = done_cnt;
        i = 0;
        wait_for(2);
        @(posedge sys_clk);
        start <= 1'b1;
        while (done_cnt - base < 32 && i < 40000)
        begin
            @(negedge sys_clk);
            i++;
        end
        hang(i);
        repeat (1000) @(negedge sys_clk);
        check(done_cnt - base, 32);
        check(ctl_busy, 1'b0);
        @(posedge sys_clk);
        start <= 1'b0;
        for (int k = 0; k < 32; k++)
            get_word(13'h1ED0);
        @(negedge sys_clk);
        check(out_valid, 1'b0);
        $display("buffer test done");
    endtask

    initial
    begin
        repeat (2) @(posedge sys_clk);
        nrst <= 1'b1;
        @(negedge sys_clk);
        check(link.sclk, 1'b1);
        check(link.sdata, 1'b1);
        check(enc_busy, 1'b0);
        t_codes();
        t_seq();
        t_repeat();
        t_abort();
        t_fifo();
        tally_and_finish();
    end
endmodule // ssi_position_encoder_readout_tb

`default_nettype wire
